// ---- hdl/srp_packetizer.sv ----
/*
 * Serial receive packetizer: collects received characters in a block buffer
 * and releases the block to the network path on length, full buffer,
 * delimiter or idle gap. Configured and observed over APB.
 * Assumes the serial receiver and the network path share the single clock,
 * so their signals are taken without synchronisers.
 */
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "srp_cfg.svh"

module srp_packetizer #(
    parameter int MS_CYCLES = `SRP_MS_NS / `SRP_CLK_NS
) (
    input wire logic clock,
    input wire logic srst,
    input wire srp_pkg::srp_apb_req_t apb_req,
    output srp_pkg::srp_apb_rsp_t apb_rsp,
    input wire srp_pkg::srp_char_t rx_char,
    output logic rx_ready,
    output srp_pkg::srp_blk_t tx_blk,
    input wire logic tx_ready
);
    import srp_pkg::*;

    // Data flow in short. Characters enter only in the fill state, one per cycle,
    // and are written to the buffer at the running count. Every accepted character
    // is tested against the length limit, the buffer size and the delimiter
    // settings in the cycle it is taken, so a release is decided on the same edge
    // that stores the character that caused it. The idle timer runs apart from the
    // character path and can release the buffer on any fill cycle without intake.
    // After a release the machine spends one cycle loading the first character
    // into the output register and then offers the block beat by beat. Intake is
    // closed until the network side has taken the last beat, which is the price
    // of a single buffer: the receiver must be able to hold off while a block
    // drains, up to 1024 beats plus any stalls of the network side.
    // Configuration writes take effect at once; changing the delimiter settings
    // while the buffer holds data applies the new settings to the rest of it.

    // Configuration and state registers.
    logic [10:0] len_reg;
    logic [19:0] delim_reg;
    logic [15:0] idle_reg;
    srp_state_t state_reg;
    logic [10:0] cnt_reg;
    logic [10:0] rel_len_reg;
    logic [10:0] rd_reg;
    logic [7:0] out_data_reg;
    logic d1_seen_reg;
    logic [1:0] extra_reg;
    logic trail_reg;
    logic [13:0] div_reg;
    logic [15:0] idle_cnt_reg;
    logic [31:0] prdata_reg;
    logic [7:0] mem [0:`SRP_DEPTH-1];

    // Field views of the delimiter register.
    wire [7:0] d1_char = delim_reg[`SRP_D1_LSB +: 8];
    wire [7:0] d2_char = delim_reg[`SRP_D2_LSB +: 8];
    wire d1_en = delim_reg[`SRP_D1_EN_BIT];
    wire d2_en = delim_reg[`SRP_D2_EN_BIT];
    wire srp_proc_t proc = srp_proc_t'(delim_reg[`SRP_PROC_LSB +: 2]);

    // One-hot views of the handling selection keep the release terms readable.
    wire proc_asis = (proc == SRP_PROC_ASIS);
    wire proc_plus1 = (proc == SRP_PROC_PLUS1);
    wire proc_plus2 = (proc == SRP_PROC_PLUS2);
    wire proc_strip = (proc == SRP_PROC_STRIP);

    // Byte offset match, used by both write and read decode.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // APB decode: the slave answers in the access cycle with no wait states.
    // The decode is shared by write and read; an unmapped offset reads as zero
    // together with the error flag, and a write to it changes nothing.
    wire apb_acc = apb_req.psel && apb_req.penable;
    wire apb_wr = apb_acc && apb_req.pwrite;
    wire sel_len = hit(apb_req.paddr, `SRP_OFS_LEN);
    wire sel_delim = hit(apb_req.paddr, `SRP_OFS_DELIM);
    wire sel_idle = hit(apb_req.paddr, `SRP_OFS_IDLE);
    wire sel_stat = hit(apb_req.paddr, `SRP_OFS_STAT);
    wire sel_any = sel_len || sel_delim || sel_idle || sel_stat;
    wire [31:0] rd_mux = sel_len ? {21'h000000, len_reg} :
        sel_delim ? {12'h000, delim_reg} :
        sel_idle ? {16'h0000, idle_reg} :
        sel_stat ? {18'h00000, state_reg, rx_ready, cnt_reg} : 32'h00000000;

    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_acc && !sel_any;
    assign apb_rsp.prdata = prdata_reg;

    // Read data is captured in the setup cycle so it is a flop in the access cycle.
    always_ff @(posedge clock)
    begin
        if (srst)
            prdata_reg <= 32'h00000000;
        else if (apb_req.psel && !apb_req.penable)
            prdata_reg <= rd_mux;
    end

    // Configuration writes. Lengths of 1025 to 2047 in bits 10:0 are clipped to 1024; higher bits are dropped.
    // Clipping keeps the full-buffer release the tightest limit, so software cannot
    // ask for a block longer than the buffer and then wait for it forever.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            len_reg <= `SRP_LEN_RST;
            delim_reg <= `SRP_DELIM_RST;
            idle_reg <= `SRP_IDLE_RST;
        end
        else if (apb_wr)
        begin
            if (sel_len)
                len_reg <= (apb_req.pwdata[10:0] > `SRP_MAX_LEN) ? `SRP_MAX_LEN
                    : apb_req.pwdata[10:0];
            if (sel_delim)
                delim_reg <= apb_req.pwdata[19:0];
            if (sel_idle)
                idle_reg <= apb_req.pwdata[15:0];
        end
    end

    // Character intake: only while filling, so the receiver stalls during a send.
    assign rx_ready = (state_reg == SRP_ST_FILL);
    wire take = rx_char.valid && rx_ready;
    wire [10:0] cnt_inc = cnt_reg + 11'h001;

    // Delimiter match on the incoming character.
    wire single_hit = d1_en && !d2_en && (rx_char.data == d1_char);
    wire pair_hit = d1_en && d2_en && d1_seen_reg && (rx_char.data == d2_char);
    wire delim_hit = take && !trail_reg && (single_hit || pair_hit);
    wire [10:0] delim_n = pair_hit ? 11'h002 : 11'h001;

    // Release conditions evaluated on an accepted character.
    wire len_hit = take && (len_reg != 11'h000) && (cnt_inc == len_reg);
    wire full_hit = take && (cnt_inc == `SRP_MAX_LEN);
    wire asis_hit = delim_hit && proc_asis;
    wire strip_hit = delim_hit && proc_strip;
    wire trail_start = delim_hit && (proc_plus1 || proc_plus2);
    wire trail_done = take && trail_reg && (extra_reg == 2'h1);

    // Idle gap: only counts while the buffer holds data and the timeout is set.
    // The tick phase is free running, so the real gap lies between one millisecond
    // less than the set value and the set value; software should leave margin above a character time.
    wire idle_on = (idle_reg != 16'h0000) && (cnt_reg != 11'h000);
    wire ms_tick = (div_reg == 14'(MS_CYCLES - 1));
    wire idle_hit = idle_on && !take && (idle_cnt_reg == idle_reg);

    // All conditions merge into one release; strip alone shortens the block.
    // Coincident terms cannot produce two blocks because they all feed one strobe.
    wire chr_rel = len_hit || full_hit || asis_hit || strip_hit || trail_done;
    wire release_now = (state_reg == SRP_ST_FILL) && (chr_rel || idle_hit);
    wire [10:0] base_len = take ? cnt_inc : cnt_reg;
    wire [10:0] new_len = strip_hit ? base_len - delim_n : base_len;

    // Buffer memory write. It carries no reset since its content is framed by the count.
    always_ff @(posedge clock)
    begin
        if (take)
            mem[cnt_reg[`SRP_ADR_W-1:0]] <= rx_char.data;
    end

    // Millisecond divider, free running. It is never restarted by a character, which
    // saves a comparator at the cost of up to one tick of jitter in the idle gap.
    always_ff @(posedge clock)
    begin
        if (srst || ms_tick)
            div_reg <= 14'h0000;
        else
            div_reg <= div_reg + 14'h0001;
    end

    // Idle counter restarts on every character and on every release.
    always_ff @(posedge clock)
    begin
        if (srst || take || !idle_on || release_now)
            idle_cnt_reg <= 16'h0000;
        else if (ms_tick && idle_cnt_reg != idle_reg)
            idle_cnt_reg <= idle_cnt_reg + 16'h0001;
    end

    // Delimiter sequence tracking and trailing character count. A release wipes
    // the pair history so a delimiter pair can never straddle two blocks.
    logic d1_seen_next;
    logic trail_next;
    logic [1:0] extra_next;
    always_comb
    begin
        d1_seen_next = d1_seen_reg;
        trail_next = trail_reg;
        extra_next = extra_reg;
        if (release_now)
        begin
            d1_seen_next = 1'b0;
            trail_next = 1'b0;
            extra_next = 2'h0;
        end
        else if (take)
        begin
            d1_seen_next = (rx_char.data == d1_char);
            if (trail_start)
            begin
                trail_next = 1'b1;
                extra_next = proc_plus1 ? 2'h1 : 2'h2;
            end
            else if (trail_reg)
            begin
                extra_next = extra_reg - 2'h1;
            end
        end
    end

    // Delimiter tracking registers.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            d1_seen_reg <= 1'b0;
            trail_reg <= 1'b0;
            extra_reg <= 2'h0;
        end
        else
        begin
            d1_seen_reg <= d1_seen_next;
            trail_reg <= trail_next;
            extra_reg <= extra_next;
        end
    end

    // Block state machine: fill, load first character, send with valid and ready.
    // The load state exists because the buffer read is registered: the first
    // character must sit in the output register before valid rises.
    wire send_beat = (state_reg == SRP_ST_SEND) && tx_ready;
    wire send_last = (rd_reg == rel_len_reg);
    srp_state_t state_next;
    logic [10:0] cnt_next;
    logic [10:0] rel_len_next;
    logic [10:0] rd_next;

    // Next-state decode; every path assigns every next value.
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        rel_len_next = rel_len_reg;
        rd_next = rd_reg;
        case (state_reg)
            SRP_ST_FILL:
            begin
                if (release_now && new_len == 11'h000)
                begin
                    // Stripped to nothing: no block goes out and the buffer empties.
                    cnt_next = 11'h000;
                end
                else if (release_now)
                begin
                    cnt_next = base_len;
                    rel_len_next = new_len;
                    rd_next = 11'h000;
                    state_next = SRP_ST_LOAD;
                end
                else if (take)
                begin
                    cnt_next = cnt_inc;
                end
            end
            SRP_ST_LOAD:
            begin
                rd_next = 11'h001;
                state_next = SRP_ST_SEND;
            end
            SRP_ST_SEND:
            begin
                if (send_beat && send_last)
                begin
                    cnt_next = 11'h000;
                    state_next = SRP_ST_FILL;
                end
                else if (send_beat)
                begin
                    rd_next = rd_reg + 11'h001;
                end
            end
            default:
            begin
                state_next = SRP_ST_FILL;
            end
        endcase
    end

    // State registers; reset leaves an empty buffer open for characters.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_reg <= SRP_ST_FILL;
            cnt_reg <= 11'h000;
            rel_len_reg <= 11'h000;
            rd_reg <= 11'h000;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            rel_len_reg <= rel_len_next;
            rd_reg <= rd_next;
        end
    end

    // Output data register, fed from the buffer one read ahead of the beat.
    // Reading ahead lets a beat be accepted every cycle with a registered data
    // output; the cost is the extra load cycle before the first beat. A stalled
    // beat keeps its data because nothing is loaded without an accepted beat.
    wire out_load = (state_reg == SRP_ST_LOAD) || (send_beat && !send_last);
    wire [9:0] out_adr = (state_reg == SRP_ST_LOAD) ? 10'h000 : rd_reg[`SRP_ADR_W-1:0];
    always_ff @(posedge clock)
    begin
        if (srst)
            out_data_reg <= 8'h00;
        else if (out_load)
            out_data_reg <= mem[out_adr];
    end

    assign tx_blk.valid = (state_reg == SRP_ST_SEND);
    assign tx_blk.last = (state_reg == SRP_ST_SEND) && send_last;
    assign tx_blk.data = out_data_reg;
endmodule : srp_packetizer

// ---- hdl/srp_cfg.svh ----
/*
 * Constants of the serial receive packetizer: register offsets, field
 * positions, reset values, buffer size and timing counts.
 * Assumes it is included by its bare name from the package and the design.
 */
`ifndef SRP_CFG_SVH
`define SRP_CFG_SVH

// Register byte offsets on the APB slave.
`define SRP_OFS_LEN 12'h000
`define SRP_OFS_DELIM 12'h004
`define SRP_OFS_IDLE 12'h008
`define SRP_OFS_STAT 12'h00C

// Field positions of the delimiter register.
`define SRP_D1_LSB 0
`define SRP_D2_LSB 8
`define SRP_D1_EN_BIT 16
`define SRP_D2_EN_BIT 17
`define SRP_PROC_LSB 18

// Reset values.
`define SRP_LEN_RST 11'h000
`define SRP_DELIM_RST 20'h00000
`define SRP_IDLE_RST 16'h0000

// Buffer size and widths.
`define SRP_DEPTH 1024
`define SRP_MAX_LEN 11'h400
`define SRP_CNT_W 11
`define SRP_ADR_W 10

// Timing: one millisecond expressed through the clock period.
`define SRP_MS_NS 1000000
`define SRP_CLK_NS 100

`endif

// ---- hdl/srp_pkg.sv ----
/*
 * Types of the serial receive packetizer.
 * Assumes srp_cfg.svh is on the include path.
 */
package srp_pkg;
    `include "srp_cfg.svh"

    // Handling applied once a delimiter sequence matched.
    typedef enum logic [1:0] {
        SRP_PROC_ASIS = 2'b00,
        SRP_PROC_PLUS1 = 2'b01,
        SRP_PROC_PLUS2 = 2'b10,
        SRP_PROC_STRIP = 2'b11
    } srp_proc_t;

    typedef enum logic [1:0] {
        SRP_ST_FILL = 2'b00,
        SRP_ST_LOAD = 2'b01,
        SRP_ST_SEND = 2'b10
    } srp_state_t;

    // One character from the serial receiver.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } srp_char_t;

    // One character of a block toward the network path.
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } srp_blk_t;

    // APB request from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } srp_apb_req_t;

    // APB answer to the master.
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } srp_apb_rsp_t;
endpackage : srp_pkg

// ---- verif/srp_properties.sv ----
/* Port checker for the serial receive packetizer.
   Assumes it is bound to srp_packetizer and sees only its ports. */
`timescale 1ns/1ps
module srp_properties (
    input wire logic clock,
    input wire logic srst,
    input wire srp_pkg::srp_apb_req_t apb_req,
    input wire srp_pkg::srp_apb_rsp_t apb_rsp,
    input wire srp_pkg::srp_char_t rx_char,
    input wire logic rx_ready,
    input wire srp_pkg::srp_blk_t tx_blk,
    input wire logic tx_ready
);
    import srp_pkg::*;
    // Access phase aimed at an offset that holds no register.
    wire acc = apb_req.psel && apb_req.penable;
    wire bad_acc = acc && !(apb_req.paddr inside {12'h000, 12'h004, 12'h008, 12'h00C});
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    chk_no_wait: assert property (apb_rsp.pready) else $error("pready low");
    chk_err_unmapped: assert property (bad_acc |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (acc && !bad_acc |-> !apb_rsp.pslverr)
        else $error("mapped access refused");
    chk_beat_hold: assert property (tx_blk.valid && !tx_ready |=> tx_blk.valid
        && $stable(tx_blk.data) && $stable(tx_blk.last)) else $error("beat changed");
    chk_rx_closed: assert property (tx_blk.valid |-> !rx_ready)
        else $error("receive open while sending");
    chk_last_reopen: assert property (tx_blk.valid && tx_blk.last && tx_ready
        |=> rx_ready && !tx_blk.valid) else $error("no refill after last beat");
    chk_valid_follows: assert property ($rose(tx_blk.valid) |-> !$past(rx_ready))
        else $error("block sent without load");
    chk_reset_state: assert property ($past(srst) && !srst |-> rx_ready && !tx_blk.valid)
        else $error("bad state after reset");
endmodule : srp_properties
bind srp_packetizer srp_properties chk (.clock(clock), .srst(srst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .rx_char(rx_char), .rx_ready(rx_ready), .tx_blk(tx_blk),
    .tx_ready(tx_ready));

// ---- verif/srp_net_sink.sv ----
/* Network path model: takes block characters and records them.
   Assumes the packetizer clock; slow turns on pseudo-random stalls. */
`timescale 1ns/1ps
module srp_net_sink (
    input wire logic clock,
    input wire logic srst,
    input wire srp_pkg::srp_blk_t tx_blk,
    input wire logic slow,
    output logic tx_ready
);
    import srp_pkg::*;
    logic [8:0] got [$];
    logic [7:0] lfsr_reg = 8'h5A;
    // Stalls vary per beat so held beats are exercised, not only fast ones.
    assign tx_ready = !slow || lfsr_reg[0];
    // Each accepted beat is stored with its last flag on top.
    always @(posedge clock)
    begin
        lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5]};
        if (!srst && tx_blk.valid && tx_ready)
            got.push_back({tx_blk.last, tx_blk.data});
    end
endmodule : srp_net_sink

// ---- verif/srp_packetizer_tb.sv ----
/* Self-checking bench: random streams under each delimiter mode, length
   limit, full buffer and idle gap. Assumes checker and sink are compiled. */
`timescale 1ns/1ps
`include "srp_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module srp_packetizer_tb;
    import srp_pkg::*;
    logic clock = 0;
    logic srst = 1;
    logic slow = 0;
    logic rx_ready;
    logic tx_ready;
    logic err;
    srp_apb_req_t apb_req = '0;
    srp_apb_rsp_t apb_rsp;
    srp_char_t rx_char = '0;
    srp_blk_t tx_blk;
    logic [31:0] rnd = 32'h00000057;
    logic [31:0] rd;
    logic [19:0] dl;
    int len;
    int n_errors = 0;
    int comparisons = 0;
    logic [7:0] sent [$];
    logic [8:0] exp_q [$];
    srp_packetizer #(.MS_CYCLES(4)) dut (.clock(clock), .srst(srst), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .rx_char(rx_char), .rx_ready(rx_ready), .tx_blk(tx_blk),
        .tx_ready(tx_ready));
    srp_net_sink sink (.clock(clock), .srst(srst), .tx_blk(tx_blk), .slow(slow),
        .tx_ready(tx_ready));
    // Clock of 100 ns.
    initial
        forever #50 clock = ~clock;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // Reference packer; flush stands for an idle release of the remainder.
    function automatic void pack(input bit flush);
        logic [7:0] b [$];
        int trail;
        int cut;
        bit rel;
        trail = 0;
        foreach (sent[i])
        begin
            b.push_back(sent[i]);
            cut = 0;
            rel = trail == 1;
            if (trail > 0)
                trail--;
            else if (dl[16] && (dl[17] ? b.size() > 1 && b[b.size()-2] == dl[7:0]
                && sent[i] == dl[15:8] : sent[i] == dl[7:0]))
            begin
                trail = dl[19:18] == 2'h1 ? 1 : dl[19:18] == 2'h2 ? 2 : 0;
                rel = trail == 0;
                cut = dl[19:18] == 2'h3 ? 1 + dl[17] : 0;
            end
            if (rel || b.size() == len || b.size() == `SRP_DEPTH || flush && i == sent.size()-1)
            begin
                for (int j = 0; j < b.size() - cut; j++)
                    exp_q.push_back({j == b.size() - cut - 1, b[j]});
                b.delete();
                trail = 0;
            end
        end
    endfunction : pack
    // APB transfer: answer taken at the rising edge that sees pready, then one idle cycle.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do
            @(posedge clock);
        while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge clock);
    endtask : apb
    // Character handshake: held until an edge sees rx_ready; valid stays up between calls.
    task automatic send(input logic [7:0] c);
        rx_char <= '{valid: 1'b1, data: c};
        do
            @(posedge clock);
        while (rx_ready !== 1'b1);
        sent.push_back(c);
    endtask : send
    task automatic drain();
        for (int k = 0; k < 5000 && sink.got.size() < exp_q.size(); k++)
            @(posedge clock);
        `CHK(sink.got.size(), exp_q.size())
        foreach (exp_q[i])
            `CHK(sink.got[i], exp_q[i])
        sink.got.delete();
        exp_q.delete();
        sent.delete();
    endtask : drain
    task automatic complete_run();
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // A hang is cut well past the expected length of the run.
    initial
    begin
        #(60000 * 100);
        n_errors++;
        complete_run();
    end
    // Main sequence: registers, then ten streams of growing variety.
    initial
    begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        apb(0, `SRP_OFS_STAT, 0);
        `CHK(rd, 32'h0000_0800)
        apb(0, 12'h010, 0);
        `CHK({err, rd}, 33'h1_0000_0000)
        apb(1, `SRP_OFS_LEN, 32'h0000_07FF);
        apb(0, `SRP_OFS_LEN, 0);
        `CHK(rd, 32'h0000_0400)
        for (int k = 0; k < 10; k++)
        begin
            rnd = xs(rnd);
            slow <= k[0];
            dl = {k[1:0] ^ {k[3], k[3]}, k[2] | k[3], k < 8, rnd[15:8] ^ 8'h5A, rnd[15:8]};
            len = k == 5 ? 6 : k == 6 ? 1 : k == 8 ? 7 : 0;
            apb(1, `SRP_OFS_DELIM, {12'h000, dl});
            apb(1, `SRP_OFS_LEN, len);
            apb(1, `SRP_OFS_IDLE, 0);
            for (int n = 0; n < (k == 9 ? 1030 : 40); n++)
            begin
                rnd = xs(rnd);
                send(rnd[2:0] < 2 ? dl[7:0] : rnd[2:0] == 2 ? dl[15:8] : rnd[15:8]);
            end
            rx_char <= '0;
            pack(0);
            for (int w = 0; w < 3000 && sink.got.size() < exp_q.size(); w++)
                @(posedge clock);
            repeat (20) @(posedge clock);
            `CHK(sink.got.size(), exp_q.size())
            exp_q.delete();
            apb(1, `SRP_OFS_IDLE, 2);
            rnd = xs(rnd);
            send(rnd[7:0]);
            rx_char <= '0;
            pack(1);
            drain();
        end
        complete_run();
    end
endmodule : srp_packetizer_tb
